// [dv/ds_partner_model.sv]
// Purpose: Downstream link partners that answer turn-off with acks
// Assumes: One ack per turn-off, later on higher ports
// Notes:   mute_i withholds the ack of a port
`timescale 1ns/10ps
module ds_partner_model #(
  parameter int NDS = 2
) (
  // Clock and reset
  input  wire logic           ref_clk_i,
  input  wire logic           rst_b_i,
  // Link side
  input  wire logic [NDS:1]   turnoff_tx_i,
  input  wire logic [NDS:1]   mute_i,
  output wire logic [NDS:1]   ack_rx_o
);
  for (genvar p = 1; p <= NDS; p++) begin : g_port
    logic [7:0] cnt;
    logic       ack;
    assign ack_rx_o[p] = ack;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        cnt <= 8'h00;
        ack <= 1'b0;
      end else begin
        ack <= (cnt == 8'h01) && !mute_i[p];
        if (turnoff_tx_i[p]) begin
          cnt <= 8'(p * 16);
        end else if (cnt != 8'h00) begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end
endmodule : ds_partner_model

// [dv/tb.sv]
// Purpose: Self-checking bench for the switch power management block
// Assumes: Slave ends each access by lowering waitrequest
// Notes:   Partner model answers turn-off downstream
`timescale 1ns/10ps
`include "swpm_cfg.svh"
module tb;
  logic                  ref_clk_i, rst_b_i, power_off_i, turnoff_rx_i, rx_err_i, other_err_i;
  logic                  avs_read_i, avs_write_i, avs_waitrequest_o, ack_tx_o;
  logic                  err_msg_o, up_l23_o, sw_low_power_o, pkt_secondary_i;
  logic [5:0]            avs_address_i;
  logic [31:0]           avs_writedata_i, avs_readdata_o, d;
  logic [2:1]            ack_rx_i, hp_event_i, ds_active_i, ds_in_l0_i, mute;
  logic [2:1]            turnoff_tx_o, pme_tx_o, ds_l23_o, ds_wake_o, tx;
  logic [2:0]            req_l1_o;
  swpm_pkg::pkt_t        pkt_i;
  swpm_pkg::verdict_t    verdict_o, v;
  int                    miscompares, check_count, n_ack, n_pme, n_wake, n_err;
  localparam logic [7:0] PK [6] = '{8'h71, 8'h69, 8'h61, 8'hC1, 8'h65, 8'h45};
  localparam logic [1:0] EX [6] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h1, 2'h0};

  always #2.5 ref_clk_i = ~ref_clk_i;

  swpm swpm_i (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .power_off_i(power_off_i), .turnoff_rx_i(turnoff_rx_i), .ack_rx_i(ack_rx_i),
    .hp_event_i(hp_event_i), .ds_active_i(ds_active_i), .ds_in_l0_i(ds_in_l0_i),
    .rx_err_i(rx_err_i), .other_err_i(other_err_i), .pkt_i(pkt_i),
    .pkt_secondary_i(pkt_secondary_i), .verdict_o(verdict_o), .err_msg_o(err_msg_o),
    .req_l1_o(req_l1_o), .turnoff_tx_o(turnoff_tx_o), .pme_tx_o(pme_tx_o),
    .ack_tx_o(ack_tx_o), .up_l23_o(up_l23_o), .ds_l23_o(ds_l23_o),
    .ds_wake_o(ds_wake_o), .sw_low_power_o(sw_low_power_o)
  );
  ds_partner_model ds_partner_model_i (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .turnoff_tx_i(turnoff_tx_o),
    .mute_i(mute), .ack_rx_o(ack_rx_i)
  );

  // ----------------------------------------------------------------
  // Pulse counters
  // ----------------------------------------------------------------
  always @(negedge ref_clk_i) begin
    if (ack_tx_o === 1'b1) n_ack++;
    if (pme_tx_o[1] === 1'b1) n_pme++;
    if (ds_wake_o[2] === 1'b1) n_wake++;
    if (err_msg_o === 1'b1) n_err++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : cyc

  task automatic rst;
    rst_b_i <= 1'b0;
    cyc(5);
    rst_b_i <= 1'b1;
    cyc(1);
  endtask : rst

  task automatic ack_wait(output logic [31:0] q);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (n > 20) begin
        miscompares++;
        test_done();
      end
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
  endtask : ack_wait

  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    ack_wait(q);
    avs_read_i <= 1'b0;
    cyc(1);
  endtask : rd

  task automatic wr(input logic [5:0] a, input logic [31:0] w);
    logic [31:0] q;
    avs_address_i <= a;
    avs_writedata_i <= w;
    avs_write_i <= 1'b1;
    ack_wait(q);
    avs_write_i <= 1'b0;
    cyc(1);
  endtask : wr

  task automatic st(input logic [5:0] a, input swpm_pkg::dstate_t e);
    logic [31:0] q;
    rd(a, q);
    chk(32'(q[1:0]), 32'(e));
  endtask : st

  task automatic go_d3(input logic [5:0] a);
    wr(a + 6'hC, 32'h1);
    wr(a, 32'(`CODE_D3HOT));
  endtask : go_d3

  task automatic send(input swpm_pkg::pkt_t p, input logic s);
    pkt_i <= p;
    pkt_secondary_i <= s;
    cyc(1);
    pkt_i <= '0;
    pkt_secondary_i <= 1'b0;
    @(negedge ref_clk_i);
    v = verdict_o;
    cyc(1);
  endtask : send

  task automatic turn_off;
    n_ack = 0;
    turnoff_rx_i <= 1'b1;
    cyc(1);
    turnoff_rx_i <= 1'b0;
    @(negedge ref_clk_i);
    tx = turnoff_tx_o;
    cyc(1);
  endtask : turn_off

  task automatic hp_pulse;
    hp_event_i <= 2'h1;
    cyc(1);
    hp_event_i <= 2'h0;
  endtask : hp_pulse

  task automatic err_pulse(input logic r, input logic o);
    n_err = 0;
    rx_err_i <= r;
    other_err_i <= o;
    cyc(1);
    rx_err_i <= 1'b0;
    other_err_i <= 1'b0;
    cyc(4);
  endtask : err_pulse

  initial begin
    cyc(100000);
    miscompares++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    rst_b_i = 1'b0;
    {power_off_i, turnoff_rx_i, rx_err_i, avs_read_i, avs_write_i, pkt_secondary_i} = '0;
    other_err_i = 1'b0;
    {avs_address_i, avs_writedata_i, hp_event_i, mute} = '0;
    pkt_i = '0;
    ds_active_i = 2'h3;
    ds_in_l0_i = 2'h1;
    rst();
    rd(6'h20, d);
    chk(32'(d[`NSR_BIT]), 32'(`NSR_RESET));
    st(6'h2C, swpm_pkg::D0_UNINIT);
    rd(6'h24, d);
    chk(32'(d[7:0]), 32'(`TMO_MAX));
    rd(6'h04, d);
    chk(d, 32'h0);
    wr(6'h24, 32'h5);
    go_d3(6'h20);
    st(6'h2C, swpm_pkg::D3_HOT);
    st(6'h3C, swpm_pkg::D0_UNINIT);
    chk(32'(req_l1_o), 32'h2);
    for (int i = 0; i < 6; i++) begin
      send(PK[i][6:0], PK[i][7]);
      chk(32'({v.ur, v.uc}), 32'(EX[i]));
    end
    chk(32'(v.route), 32'h1);
    err_pulse(1'b1, 1'b0);
    chk(32'(n_err), 32'h1);
    err_pulse(1'b0, 1'b1);
    chk(32'(n_err), 32'h1);
    wr(6'h20, 32'(`CODE_D0));
    st(6'h2C, swpm_pkg::D0_UNINIT);
    rd(6'h24, d);
    chk(32'(d[7:0]), 32'h5);
    $display("test power states done");
    go_d3(6'h20);
    wr(6'h24, 32'h1);
    n_pme = 0;
    hp_pulse();
    cyc(700);
    chk(32'(n_pme >= 2), 32'h1);
    wr(6'h20, 32'h8003);
    n_pme = 0;
    cyc(700);
    chk(32'(n_pme), 32'h0);
    power_off_i <= 1'b1;
    cyc(2);
    hp_pulse();
    cyc(700);
    chk(32'(n_pme), 32'h0);
    st(6'h2C, swpm_pkg::D3_COLD);
    power_off_i <= 1'b0;
    $display("test pme retry done");
    rst();
    go_d3(6'h10);
    err_pulse(1'b0, 1'b1);
    chk(32'(n_err), 32'h0);
    err_pulse(1'b1, 1'b0);
    chk(32'(n_err), 32'h1);
    turn_off();
    chk(32'(tx), 32'h3);
    cyc(25);
    chk(32'(n_ack), 32'h0);
    cyc(40);
    chk(32'({n_ack == 1, up_l23_o, sw_low_power_o}), 32'h7);
    send(7'h61, 1'b0);
    chk(32'(v.drop), 32'h1);
    $display("test aggregation done");
    rst();
    n_wake = 0;
    turn_off();
    send(7'h42, 1'b0);
    chk(32'(v.fwd), 32'h1);
    cyc(80);
    chk(32'(n_ack), 32'h0);
    chk(32'(ds_l23_o), 32'h3);
    chk(32'(n_wake >= 1), 32'h1);
    $display("test abandon done");
    rst();
    wr(6'h38, 32'h1);
    mute <= 2'h2;
    turn_off();
    cyc(700);
    chk(32'({n_ack == 1, ds_l23_o[2]}), 32'h3);
    rst();
    mute <= 2'h0;
    ds_active_i <= 2'h1;
    turn_off();
    chk(32'(tx), 32'h1);
    cyc(60);
    chk(32'(n_ack), 32'h1);
    $display("test timeout and active ports done");
    test_done();
  end
endmodule : tb

// [hw/swpm.sv]
// Purpose: Per-port power states, PME retry and turn-off ack aggregation
// Assumes: Port 0 upstream, ports 1..NDS downstream; packet classification upstream
// Notes:   Registers on Avalon-MM, one cycle waitrequest per access
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "swpm_cfg.svh"

module swpm #(
  parameter int NDS = 2
) (
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_b_i,
  // Avalon-MM slave
  input  wire logic [5:0]           avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [31:0]          avs_writedata_i,
  output logic [31:0]               avs_readdata_o,
  output logic                      avs_waitrequest_o,
  // Power and events
  input  wire logic                 power_off_i,
  input  wire logic                 turnoff_rx_i,
  input  wire logic [NDS:1]         ack_rx_i,
  input  wire logic [NDS:1]         hp_event_i,
  input  wire logic [NDS:1]         ds_active_i,
  input  wire logic [NDS:1]         ds_in_l0_i,
  input  wire logic                 rx_err_i,
  input  wire logic                 other_err_i,
  // Received packet, classified
  input  wire swpm_pkg::pkt_t       pkt_i,
  input  wire logic                 pkt_secondary_i,
  // Outputs
  output swpm_pkg::verdict_t        verdict_o,
  output logic                      err_msg_o,
  output logic [NDS:0]              req_l1_o,
  output logic [NDS:1]              turnoff_tx_o,
  output logic [NDS:1]              pme_tx_o,
  output logic                      ack_tx_o,
  output logic                      up_l23_o,
  output logic [NDS:1]              ds_l23_o,
  output logic [NDS:1]              ds_wake_o,
  output logic                      sw_low_power_o
);
  // Port select is two bits wide, so at most three downstream ports
  if (NDS < 1 || NDS > 3) begin : g_bad_nds
    $error("NDS out of range");
  end

  localparam int NP = NDS + 1;
  swpm_pkg::dstate_t dst [NP];
  logic [1:0] psf [NP];
  logic [NP-1:0] nsr, cfg_done;
  logic [NDS:1] pme_status_bit;
  logic [7:0] pme_to [NDS+1];
  logic [7:0] ack_to [NDS+1];
  logic [8:0] pme_cnt [NDS+1];
  logic [8:0] ack_cnt [NDS+1];
  logic [NDS:1] ack_got, ack_wait;
  swpm_pkg::agg_t agg;
  logic [7:0] tick_cnt;
  logic tick;
  logic acc_done;
  logic wr_hit, rd_hit;
  logic [1:0] port_sel;
  logic [1:0] reg_sel;
  logic glob_sel;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign glob_sel = (avs_address_i[5:4] == 2'h0);
  assign port_sel = 2'(avs_address_i[5:4] - 2'h1);
  assign reg_sel  = avs_address_i[3:2];
  // Writes land on the edge that ends the wait, when waitrequest is low
  assign wr_hit   = avs_write_i && acc_done && !glob_sel && (32'(port_sel) < NP);
  assign rd_hit   = avs_read_i && !acc_done;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_done <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      acc_done <= (avs_read_i || avs_write_i) && !acc_done;
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !acc_done);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_hit) begin
      avs_readdata_o <= 32'h0000_0000;
      if (glob_sel) begin
        avs_readdata_o <= {29'h0, (agg == swpm_pkg::AG_DONE), sw_low_power_o, up_l23_o};
      end else if (32'(port_sel) < NP) begin
        case (reg_sel)
          `OFS_PM_CONTROL_STATUS_REG: avs_readdata_o <= {16'h0,
              (port_sel != 2'h0) ? pme_status_bit[port_sel] : 1'b0, 11'h0, nsr[port_sel], 1'b0,
              psf[port_sel]};
          `OFS_PME_RETRY: avs_readdata_o <= {24'h0, pme_to[port_sel]};
          `OFS_TOACK: avs_readdata_o <= {24'h0, ack_to[port_sel]};
          `OFS_CTRL: avs_readdata_o <= {28'h0, 1'(dst[port_sel]) , 1'b0, 2'(dst[port_sel])};
          default: avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt <= 8'h00;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == 8'(`TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == 8'(`TICK_CYCLES - 1)) ? 8'h00 : tick_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Per-port power state
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_port
      logic wr_me;
      assign wr_me = wr_hit && (port_sel == 2'(g));
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          dst[g] <= swpm_pkg::D0_UNINIT;
          psf[g] <= `CODE_D0;
          nsr[g] <= `NSR_RESET;
          cfg_done[g] <= 1'b0;
          pme_to[g] <= `TMO_MAX;
          ack_to[g] <= `TMO_MAX;
        end else begin
          // Each port's state changes only by its own writes, except D3hot to D3cold on power_off_i
          if (wr_me && reg_sel == `OFS_PME_RETRY) pme_to[g] <= avs_writedata_i[7:0];
          if (wr_me && reg_sel == `OFS_TOACK) ack_to[g] <= avs_writedata_i[7:0];
          if (wr_me && reg_sel == `OFS_CTRL) cfg_done[g] <= avs_writedata_i[0];
          if (wr_me && reg_sel == `OFS_PM_CONTROL_STATUS_REG) begin
            psf[g] <= avs_writedata_i[1:0];
            nsr[g] <= avs_writedata_i[`NSR_BIT];
          end
          case (dst[g])
            swpm_pkg::D0_UNINIT:
              if (cfg_done[g]) dst[g] <= swpm_pkg::D0_ACTIVE;
            swpm_pkg::D0_ACTIVE: begin
              if (wr_me && reg_sel == `OFS_PM_CONTROL_STATUS_REG && avs_writedata_i[1:0] == `CODE_D3HOT)
                dst[g] <= swpm_pkg::D3_HOT;
            end
            swpm_pkg::D3_HOT: begin
              if (power_off_i) dst[g] <= swpm_pkg::D3_COLD;
              else if (wr_me && reg_sel == `OFS_PM_CONTROL_STATUS_REG && avs_writedata_i[1:0] == `CODE_D0) begin
                dst[g] <= swpm_pkg::D0_UNINIT;
                cfg_done[g] <= 1'b0;
              end
            end
            swpm_pkg::D3_COLD: dst[g] <= swpm_pkg::D3_COLD;
            default: dst[g] <= swpm_pkg::D0_UNINIT;
          endcase
        end
      end
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) req_l1_o[g] <= 1'b0;
        else req_l1_o[g] <= (dst[g] == swpm_pkg::D3_HOT);
      end
      l1_follow_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        req_l1_o[g] == $past(dst[g] == swpm_pkg::D3_HOT))
        else $error("L1 request does not follow D3hot");
    end

    // ----------------------------------------------------------------
    // Downstream PME retry and turn-off ack timers
    // ----------------------------------------------------------------
    for (g = 1; g <= NDS; g++) begin : g_ds
      logic pme_ok;
      logic [8:0] pme_load, ack_load;
      assign pme_ok = (dst[g] == swpm_pkg::D3_HOT) || (dst[0] == swpm_pkg::D3_HOT);
      assign pme_load = (pme_to[g] == 8'h00) ? 9'h100 : {1'b0, pme_to[g]};
      assign ack_load = (ack_to[g] == 8'h00) ? 9'h100 : {1'b0, ack_to[g]};
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          pme_status_bit[g] <= 1'b0;
          pme_cnt[g] <= 9'h000;
          pme_tx_o[g] <= 1'b0;
        end else begin
          pme_tx_o[g] <= 1'b0;
          // Set wins over software clear
          if (hp_event_i[g] && pme_ok && dst[g] != swpm_pkg::D3_COLD) begin
            pme_status_bit[g] <= 1'b1;
            if (!pme_status_bit[g]) begin
              pme_tx_o[g] <= 1'b1;
              pme_cnt[g] <= pme_load;
            end
          end else if (wr_hit && port_sel == 2'(g) && reg_sel == `OFS_PM_CONTROL_STATUS_REG
                       && avs_writedata_i[`PME_STATUS_BIT_BIT]) begin
            pme_status_bit[g] <= 1'b0;
          end
          if (pme_status_bit[g] && pme_cnt[g] != 9'h000 && tick) begin
            if (pme_cnt[g] == 9'h001 && dst[g] != swpm_pkg::D3_COLD) begin
              pme_tx_o[g] <= 1'b1;
              pme_cnt[g] <= pme_load;
            end else pme_cnt[g] <= pme_cnt[g] - 9'h001;
          end
        end
      end
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          ack_got[g] <= 1'b0;
          ack_wait[g] <= 1'b0;
          ack_cnt[g] <= 9'h000;
          turnoff_tx_o[g] <= 1'b0;
          ds_l23_o[g] <= 1'b0;
          ds_wake_o[g] <= 1'b0;
        end else begin
          turnoff_tx_o[g] <= 1'b0;
          ds_wake_o[g] <= 1'b0;
          if (turnoff_rx_i && ds_active_i[g]) begin
            turnoff_tx_o[g] <= 1'b1;
            ack_wait[g] <= 1'b1;
            ack_got[g] <= 1'b0;
            ack_cnt[g] <= ack_load;
          end else if (ack_wait[g]) begin
            // Keeps running after abandonment
            if (ack_rx_i[g] || (tick && ack_cnt[g] == 9'h001)) begin
              ack_wait[g] <= 1'b0;
              ack_got[g] <= 1'b1;
              ds_l23_o[g] <= 1'b1;
            end else if (tick) ack_cnt[g] <= ack_cnt[g] - 9'h001;
          end
          if (pkt_i.valid && !pkt_i.to_self && pkt_i.port == 2'(g)
              && agg == swpm_pkg::AG_WAIT && !ds_in_l0_i[g]) begin
            ds_wake_o[g] <= 1'b1;
            ds_l23_o[g] <= 1'b0;
          end
        end
      end
      pme_retry_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (pme_status_bit[g] && tick && pme_cnt[g] == 9'h001 && dst[g] != swpm_pkg::D3_COLD)
        |=> pme_tx_o[g]) else $error("PME not resent");
      ack_tmo_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (ack_wait[g] && !turnoff_rx_i && tick && ack_cnt[g] == 9'h001)
        |=> ack_got[g]) else $error("ack timeout not counted");
      abandon_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (agg == swpm_pkg::AG_ABANDON && ack_wait[g] && ack_rx_i[g] && !turnoff_rx_i)
        |=> ack_got[g]) else $error("downstream handshake dropped");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Ack aggregation
  // ----------------------------------------------------------------
  logic all_acked;
  assign all_acked = &(ack_got | ~ds_active_i);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      agg <= swpm_pkg::AG_IDLE;
      ack_tx_o <= 1'b0;
      up_l23_o <= 1'b0;
      sw_low_power_o <= 1'b0;
    end else begin
      ack_tx_o <= 1'b0;
      case (agg)
        swpm_pkg::AG_IDLE:
          if (turnoff_rx_i) agg <= swpm_pkg::AG_WAIT;
        swpm_pkg::AG_WAIT:
          if (pkt_i.valid && !pkt_secondary_i) agg <= swpm_pkg::AG_ABANDON;
          else if (all_acked && !(|ack_wait)) begin
            ack_tx_o <= 1'b1;
            up_l23_o <= 1'b1;
            agg <= swpm_pkg::AG_DONE;
          end
        swpm_pkg::AG_ABANDON:
          if (turnoff_rx_i) agg <= swpm_pkg::AG_WAIT;
        swpm_pkg::AG_DONE:
          if (turnoff_rx_i) agg <= swpm_pkg::AG_WAIT;
          else sw_low_power_o <= (dst[0] == swpm_pkg::D3_HOT);
        default: agg <= swpm_pkg::AG_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Packet verdicts
  // ----------------------------------------------------------------
  logic tgt_d3;
  assign tgt_d3 = (dst[pkt_i.port] == swpm_pkg::D3_HOT);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      verdict_o <= '0;
      err_msg_o <= 1'b0;
    end else begin
      verdict_o <= '0;
      err_msg_o <= rx_err_i || (other_err_i && !tgt_d3);
      if (pkt_i.valid) begin
        if (agg == swpm_pkg::AG_DONE && !pkt_secondary_i) verdict_o.drop <= 1'b1;
        else if (pkt_i.is_cpl) begin
          if (pkt_i.to_self && tgt_d3) verdict_o.uc <= 1'b1;
          else verdict_o.route <= 1'b1;
        end else if (tgt_d3 && (pkt_secondary_i ||
                     !(pkt_i.to_self && (pkt_i.is_cfg0 || pkt_i.is_msg))))
          verdict_o.ur <= 1'b1;
        else if (pkt_i.to_self) verdict_o.route <= 1'b1;
        else verdict_o.fwd <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_turnoff; turnoff_rx_i; endsequence
  sequence s_bcast; turnoff_tx_o[1] || !ds_active_i[1]; endsequence
  bcast_turnoff_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_turnoff |=> s_bcast)
    else $error("turn-off not broadcast");
  ack_after_all_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ack_tx_o |-> $past(all_acked))
    else $error("early upstream ack");
  abandon_agg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (agg == swpm_pkg::AG_WAIT && pkt_i.valid && !pkt_secondary_i) |=> !ack_tx_o)
    else $error("ack after abandon");
  d3_l1_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (dst[0] == swpm_pkg::D3_HOT) |=> req_l1_o[0])
    else $error("no L1 request");
  no_cold_pme_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $past(dst[1] == swpm_pkg::D3_COLD) |-> !pme_tx_o[1])
    else $error("PME from D3cold");
  cpl_uc_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (pkt_i.valid && pkt_i.is_cpl && pkt_i.to_self && tgt_d3 && agg != swpm_pkg::AG_DONE)
    |=> verdict_o.uc) else $error("completion not UC");
  d3_to_d0_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (dst[1] == swpm_pkg::D3_HOT ##1 dst[1] == swpm_pkg::D0_UNINIT)
    |-> ($stable(pme_to[1]) && $stable(ack_to[1]))) else $error("register reset on wake");
  sec_ur_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (pkt_i.valid && pkt_secondary_i && !pkt_i.is_cpl && tgt_d3) |=> verdict_o.ur)
    else $error("secondary request not UR");
  drop_done_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (pkt_i.valid && !pkt_secondary_i && agg == swpm_pkg::AG_DONE) |=> verdict_o.drop)
    else $error("packet after ack not dropped");
  low_power_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (agg == swpm_pkg::AG_DONE && !turnoff_rx_i && dst[0] == swpm_pkg::D3_HOT)
    |=> sw_low_power_o) else $error("switch not in low power");
  pass_cpl_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (pkt_i.valid && pkt_i.is_cpl && !pkt_i.to_self && agg != swpm_pkg::AG_DONE)
    |=> verdict_o.route) else $error("passing completion not routed");
  wait_one_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
endmodule : swpm

// [hw/swpm_cfg.svh]
// Purpose: Constants for the switch power management block
// Assumes: 200 MHz core clock
// Notes:   Global and port base offsets are byte addresses; per-port register offsets are word indices
`ifndef SWPM_CFG_SVH
`define SWPM_CFG_SVH
// ----------------------------------------------------------------
// Register map (word aligned)
// ----------------------------------------------------------------
`define OFS_GLOBAL        6'h00
`define OFS_PORT_BASE     6'h10
`define OFS_PORT_STRIDE   6'h10
`define OFS_PM_CONTROL_STATUS_REG         2'h0
`define OFS_PME_RETRY     2'h1
`define OFS_TOACK         2'h2
`define OFS_CTRL          2'h3
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PSF_LSB           0
`define NSR_BIT           3
`define PME_STATUS_BIT_BIT          15
`define CODE_D0           2'h0
`define CODE_D3HOT        2'h3
`define NSR_RESET         1'b1
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ           200
`define TICK_US           1
`define TICK_CYCLES       (`TICK_US * `CLK_MHZ)
`define TMO_MAX           8'hFF
`endif

// [hw/swpm_pkg.sv]
// Purpose: Types for the switch power management block
// Assumes: Constants come from swpm_cfg.svh
// Notes:   None
package swpm_pkg;
  typedef enum logic [1:0] {D0_UNINIT, D0_ACTIVE, D3_HOT, D3_COLD} dstate_t;
  typedef enum logic [1:0] {AG_IDLE, AG_WAIT, AG_ABANDON, AG_DONE} agg_t;
  typedef struct packed {
    logic valid;
    logic to_self;
    logic is_cfg0;
    logic is_msg;
    logic is_cpl;
    logic [1:0] port;
  } pkt_t;
  typedef struct packed {
    logic ur;
    logic uc;
    logic route;
    logic fwd;
    logic drop;
  } verdict_t;
endpackage : swpm_pkg
